//--- design/fspc_defines.vh
/*
 * Constants of the flash self-program controller: register byte
 * addresses, control field positions, reset values and timing counts.
 * Assumes a 32-bit AHB-Lite slave with one register per aligned word.
 */
// Overview of operation
// - Flash is rows of 14-bit words; erase acts on a whole row only.
// - Data is staged in hidden 14-bit latches loaded via data register pair.
// - Rows are 32 words with 32 latch words; one program covers one row.
// - Read occurs in second cycle after read set; that slot is ignored.
// - Read word appears in data pair the cycle after the read slot.
// - Data pair holds its value until next read or a software write.
// - Erase, latch load or write happen only after a complete unlock.
// - Setting the write bit always forces two no-op slots.
// - Row erase or program stalls the core about 2 ms, then resumes.
// - Latch-only load forces two no-op slots then continues unstalled.
// - Erase needs two set-up cycles after write bit, filled by no-ops.
// - During erase halt clocks and peripherals keep running; not sleep.
// - After erase the core resumes at third instruction after write set.
// - Blank words may be written without erase; else save, erase, rewrite.
// - Read and write bits are set-only; hardware clears them when done.
// - Write or erase only while write permit set; permit clear at reset.
// - Unlock key register is write-only and reads as zero.
// - A reset that interrupts a write sets the write abort flag.
`ifndef FSPC_DEFINES_VH
`define FSPC_DEFINES_VH

`define FSPC_ADDR_LOW     12'h000
`define FSPC_ADDR_HIGH    12'h004
`define FSPC_DATA_LOW     12'h008
`define FSPC_DATA_HIGH    12'h00c
`define FSPC_CONTROL      12'h010
`define FSPC_UNLOCK_KEY   12'h014

`define FSPC_B_READ       0
`define FSPC_B_WRITE      1
`define FSPC_B_PERMIT     2
`define FSPC_B_ABORT      3
`define FSPC_B_LATCH_ONLY 5
`define FSPC_B_ERASE      4
`define FSPC_B_CFG_SEL    6

`define FSPC_KEY_FIRST    8'h55
`define FSPC_KEY_SECOND   8'haa
`define FSPC_BLANK_WORD   14'h3fff
`define FSPC_ROW_WORDS    32

`define FSPC_OP_TIME_US   2000
`define FSPC_CLK_MHZ      100
`define FSPC_FORCED_NOPS  2

`endif

//--- design/fspc_flash_self_program_control.v
/*
 * Flash self-program controller with its own flash array model,
 * write latches and AHB-Lite register slave.
 * The array and latches are behavioural; there is no pump or verify,
 * and an operation ends after a fixed count of clocks.
 * Assumes one AHB-Lite master, word accesses, and that the core
 * honours the stall output by holding its instruction pipeline.
 */
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "fspc_defines.vh"

module fspc_flash_self_program_control #(
    parameter OP_CYCLES = `FSPC_OP_TIME_US * `FSPC_CLK_MHZ
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        reset_n,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Core sequencing
    input  wire        instr_retire,
    output wire        force_nop,
    output wire        core_stall,
    output wire        clocks_running
);

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    localparam WORDS = 1024;
    // The array is kept small; the upper address bits are ignored.
    // Words that were never written read as unknown until a row erase
    // puts them in the blank state.
    reg [13:0] flash_mem [0:WORDS-1];
    // The latches return to the blank pattern after every program or
    // erase, so a row write only changes the words software loaded.
    reg [13:0] latch_mem [0:`FSPC_ROW_WORDS-1];

    // Register fields seen by software.
    reg [7:0]  flash_addr_low_q;
    reg [6:0]  flash_addr_high_q;
    reg [7:0]  flash_data_low_q;
    reg [5:0]  flash_data_high_q;
    reg        read_q;
    reg        write_q;
    reg        write_permit_q;
    reg        write_abort_flag_q;
    reg        erase_q;
    reg        latch_only_q;
    reg        config_space_select_q;
    reg [1:0]  unlock_q;
    // Set while a row erase or program is pending or running.
    reg        write_active_q;

    // Sequencer: read slot, read cycle, forced slots, long operation.
    localparam S_IDLE  = 3'd0;
    localparam S_RSLOT = 3'd1;
    localparam S_RREAD = 3'd2;
    localparam S_NOP   = 3'd3;
    localparam S_BUSY  = 3'd4;
    reg [2:0]  state_q;
    reg [1:0]  nop_cnt_q;
    // Wide enough for the full operation time at the system clock.
    reg [31:0] op_cnt_q;

    // Only 1024 words are modelled: the upper five bits of the word
    // address pick the row, the lower five pick the write latch.
    wire [9:0] word_addr = {flash_addr_high_q[1:0], flash_addr_low_q};
    wire [4:0] row_addr  = word_addr[9:5];
    wire [4:0] latch_idx = word_addr[4:0];

    // -----------------------------------------------------------------
    // Bus address phase capture
    // -----------------------------------------------------------------
    // Writes act in the data phase, when hwdata is valid for the
    // captured address; the address is captured on every clock.
    // Access size is not checked: only whole words are expected.
    reg        dp_wr_q;
    reg        dp_rd_q;
    reg [11:0] dp_addr_q;
    wire       take = hsel & hready & htrans[1];

    // Every register answers at once: no wait states, no error response.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dp_wr_q   <= 1'b0;
            dp_rd_q   <= 1'b0;
            dp_addr_q <= 12'h000;
        end else begin
            dp_wr_q   <= take & hwrite;
            dp_rd_q   <= take & ~hwrite;
            dp_addr_q <= haddr;
        end
    end

    // True in the data phase of a write to the given register.
    function wr_at;
        input [11:0] a;
        begin
            wr_at = dp_wr_q && (dp_addr_q == a);
        end
    endfunction

    // -----------------------------------------------------------------
    // Read data, taken from registers in the data phase
    // -----------------------------------------------------------------
    // Zero outside a read data phase, so an idle bus shows no stale data.
    always @* begin
        hrdata = 32'h0000_0000;
        if (dp_rd_q) begin
            case (dp_addr_q)
                `FSPC_ADDR_LOW:   hrdata = {24'h000000, flash_addr_low_q};
                `FSPC_ADDR_HIGH:  hrdata = {25'h0, flash_addr_high_q};
                `FSPC_DATA_LOW:   hrdata = {24'h000000, flash_data_low_q};
                `FSPC_DATA_HIGH:  hrdata = {26'h0, flash_data_high_q};
                `FSPC_CONTROL:    hrdata = {25'h0,
                                            config_space_select_q,
                                            latch_only_q, erase_q,
                                            write_abort_flag_q,
                                            write_permit_q, write_q,
                                            read_q};
                `FSPC_UNLOCK_KEY: hrdata = 32'h0000_0000;
                default:          hrdata = 32'h0000_0000;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Unlock tracker
    // -----------------------------------------------------------------
    // Any bus access other than the expected next step voids progress.
    // A second 55h does not restart the count: software begins again
    // from the first key after any slip.
    wire key_wr  = wr_at(`FSPC_UNLOCK_KEY);
    wire ctl_wr  = wr_at(`FSPC_CONTROL);
    wire wr_req  = ctl_wr & hwdata[`FSPC_B_WRITE] & ~write_q;
    // The permit bit must already be set and be written again with the
    // write bit; a read request that comes with the write bit is dropped,
    // so a write start is never lost to it.
    wire go_ok   = wr_req & (unlock_q == 2'd2) & write_permit_q &
                   hwdata[`FSPC_B_PERMIT];
    wire rd_req  = ctl_wr & hwdata[`FSPC_B_READ] & ~read_q &
                   ~hwdata[`FSPC_B_WRITE];

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            unlock_q <= 2'd0;
        end else if (key_wr) begin
            if (unlock_q == 2'd0 && hwdata[7:0] == `FSPC_KEY_FIRST)
                unlock_q <= 2'd1;
            else if (unlock_q == 2'd1 && hwdata[7:0] == `FSPC_KEY_SECOND)
                unlock_q <= 2'd2;
            else
                unlock_q <= 2'd0;
        end else if (dp_wr_q || dp_rd_q) begin
            unlock_q <= 2'd0;
        end
    end

    // -----------------------------------------------------------------
    // Core sequencing outputs
    // -----------------------------------------------------------------
    // The core keeps retiring slots as no-ops while this is high, so the
    // sequencer can count them; the stall covers only the long operation.
    assign force_nop      = (state_q == S_RSLOT) || (state_q == S_RREAD) ||
                            (state_q == S_NOP);
    assign core_stall     = (state_q == S_BUSY);
    // The long operation only holds the core; clocks keep running, so
    // it is not a sleep state.
    assign clocks_running = 1'b1;

    // -----------------------------------------------------------------
    // Registers and sequencer
    // -----------------------------------------------------------------
    integer i;
    // Combinational array read of the addressed word.
    wire [13:0] cur_word = flash_mem[word_addr];

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q               <= S_IDLE;
            nop_cnt_q             <= 2'd0;
            op_cnt_q              <= 32'd0;
            flash_addr_low_q      <= 8'h00;
            flash_addr_high_q     <= 7'h00;
            flash_data_low_q      <= 8'h00;
            flash_data_high_q     <= 6'h00;
            read_q                <= 1'b0;
            write_q               <= 1'b0;
            write_permit_q        <= 1'b0;
            erase_q               <= 1'b0;
            latch_only_q          <= 1'b0;
            config_space_select_q <= 1'b0;
            write_active_q        <= 1'b0;
            // Latches come up blank so a first row write has no unknowns.
            for (i = 0; i < `FSPC_ROW_WORDS; i = i + 1)
                latch_mem[i] <= `FSPC_BLANK_WORD;
        end else begin
            if (wr_at(`FSPC_ADDR_LOW))
                flash_addr_low_q <= hwdata[7:0];
            if (wr_at(`FSPC_ADDR_HIGH))
                flash_addr_high_q <= hwdata[6:0];
            if (wr_at(`FSPC_DATA_LOW))
                flash_data_low_q <= hwdata[7:0];
            if (wr_at(`FSPC_DATA_HIGH))
                flash_data_high_q <= hwdata[5:0];
            if (ctl_wr) begin
                write_permit_q        <= hwdata[`FSPC_B_PERMIT];
                erase_q               <= hwdata[`FSPC_B_ERASE];
                latch_only_q          <= hwdata[`FSPC_B_LATCH_ONLY];
                config_space_select_q <= hwdata[`FSPC_B_CFG_SEL];
            end
            case (state_q)
                S_IDLE: begin
                    if (go_ok) begin
                        write_q   <= 1'b1;
                        nop_cnt_q <= 2'd0;
                        state_q   <= S_NOP;
                        // Latch-only loads mark no write as active unless the erase bit is also set.
                        write_active_q <= ~hwdata[`FSPC_B_LATCH_ONLY] |
                                          hwdata[`FSPC_B_ERASE];
                    end else if (rd_req) begin
                        read_q  <= 1'b1;
                        state_q <= S_RSLOT;
                    end
                end
                S_RSLOT: begin
                    // The first retired slot is the ignored one.
                    if (instr_retire)
                        state_q <= S_RREAD;
                end
                S_RREAD: begin
                    // The pair holds this until a later read or bus write.
                    // Config space is not modelled; it reads blank.
                    if (config_space_select_q) begin
                        flash_data_low_q  <= 8'hff;
                        flash_data_high_q <= 6'h3f;
                    end else begin
                        flash_data_low_q  <= cur_word[7:0];
                        flash_data_high_q <= cur_word[13:8];
                    end
                    read_q  <= 1'b0;
                    state_q <= S_IDLE;
                end
                S_NOP: begin
                    // Two slots are forced whatever the operation.
                    if (instr_retire) begin
                        nop_cnt_q <= nop_cnt_q + 2'd1;
                        if (nop_cnt_q == 2'd`FSPC_FORCED_NOPS - 2'd1) begin
                            if (latch_only_q && !erase_q) begin
                                latch_mem[latch_idx] <=
                                    {flash_data_high_q, flash_data_low_q};
                                write_q <= 1'b0;
                                state_q <= S_IDLE;
                            end else begin
                                // The last word is loaded with the row
                                // write itself, as software expects.
                                latch_mem[latch_idx] <=
                                    {flash_data_high_q, flash_data_low_q};
                                op_cnt_q <= 32'd0;
                                state_q  <= S_BUSY;
                            end
                        end
                    end
                end
                S_BUSY: begin
                    // The addressed row changes on the last count, unless config space is selected; the latches are blanked either way.
                    op_cnt_q <= op_cnt_q + 32'd1;
                    if (op_cnt_q == OP_CYCLES - 1) begin
                        if (!config_space_select_q) begin
                            for (i = 0; i < `FSPC_ROW_WORDS; i = i + 1) begin
                                if (erase_q)
                                    flash_mem[{row_addr, i[4:0]}] <=
                                        `FSPC_BLANK_WORD;
                                else
                                    flash_mem[{row_addr, i[4:0]}] <=
                                        flash_mem[{row_addr, i[4:0]}] &
                                        latch_mem[i];
                            end
                        end
                        for (i = 0; i < `FSPC_ROW_WORDS; i = i + 1)
                            latch_mem[i] <= `FSPC_BLANK_WORD;
                        write_q        <= 1'b0;
                        write_active_q <= 1'b0;
                        state_q        <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Abort flag
    // -----------------------------------------------------------------
    // The flag must survive the reset that causes it, so it is sampled
    // from the active-write marker once reset releases.
    // A clean reset clears it, so until a software clear it describes the last reset.
    // High for the first clock after reset releases.
    reg reset_seen_q;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            reset_seen_q <= 1'b1;
        else
            reset_seen_q <= 1'b0;
    end

    // No reset term: it must keep its value through the reset.
    reg was_writing_q;
    always @(posedge clk_sys) begin
        was_writing_q <= reset_n ? write_active_q : was_writing_q;
    end

    // Software clears the flag by writing zero to its bit; the report
    // of a cut operation wins over a clear in the same clock.
    always @(posedge clk_sys) begin
        if (reset_seen_q && reset_n) begin
            if (was_writing_q)
                write_abort_flag_q <= 1'b1;
            else
                write_abort_flag_q <= 1'b0;
        end else if (ctl_wr && !hwdata[`FSPC_B_ABORT]) begin
            write_abort_flag_q <= 1'b0;
        end
    end

endmodule

//--- bench/fspc_flash_self_program_control_asserts.sv
/*
 * Port checker for the flash self-program controller.
 * Assumes zero-wait AHB-Lite timing and a core that pulses retire.
 */
`timescale 1ns/1ps
`include "fspc_defines.vh"
module fspc_flash_self_program_control_asserts #(
    parameter OP_CYCLES = 20
) (
    input wire        clk_sys,
    input wire        reset_n,
    input wire        hsel,
    input wire [11:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        instr_retire,
    input wire        force_nop,
    input wire        core_stall,
    input wire        clocks_running
);
    // ------------------------------------------------------------
    // Data-phase trackers
    // ------------------------------------------------------------
    reg        rd_q, key_q, ctl_q, wr_q;
    reg [31:0] stall_q;
    reg [2:0]  nop_q;
    wire       take = hsel & hready & htrans[1];
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            {rd_q, key_q, ctl_q, wr_q} <= 4'h0;
            stall_q <= 32'h0;
            nop_q   <= 3'h0;
        end else begin
            rd_q    <= take & ~hwrite;
            key_q   <= take & ~hwrite & (haddr == `FSPC_UNLOCK_KEY);
            ctl_q   <= take & ~hwrite & (haddr == `FSPC_CONTROL);
            wr_q    <= take & hwrite & (haddr == `FSPC_CONTROL);
            stall_q <= core_stall ? stall_q + 32'h1 : 32'h0;
            nop_q   <= force_nop ? nop_q + {2'h0, instr_retire} : 3'h0;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_clk_run; clocks_running == 1'b1; endproperty
    a_clk_run: assert property (p_clk_run)
        else $error("clocks stopped");
    property p_key_zero; key_q |-> hrdata == 32'h0; endproperty
    a_key_zero: assert property (p_key_zero)
        else $error("unlock key read not zero");
    property p_idle_zero; !rd_q |-> hrdata == 32'h0; endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data outside data phase");
    property p_ctl_clear;
        ctl_q && !force_nop && !core_stall && !$past(core_stall, 2)
            |-> hrdata[1:0] == 2'b00;
    endproperty
    a_ctl_clear: assert property (p_ctl_clear)
        else $error("read or write bit left set");
    property p_stall_len; $fell(core_stall) |-> stall_q == OP_CYCLES;
    endproperty
    a_stall_len: assert property (p_stall_len)
        else $error("stall length wrong");
    property p_stall_max; core_stall |-> stall_q < OP_CYCLES; endproperty
    a_stall_max: assert property (p_stall_max)
        else $error("stall too long");
    property p_nop_cnt; nop_q <= 3'h2; endproperty
    a_nop_cnt: assert property (p_nop_cnt)
        else $error("too many forced slots");
    property p_stall_setup; $rose(core_stall) |-> $past(force_nop);
    endproperty
    a_stall_setup: assert property (p_stall_setup)
        else $error("stall without set-up slots");
    property p_nop_cause;
        $rose(force_nop) |-> $past(wr_q) || $past(wr_q, 2) || wr_q;
    endproperty
    a_nop_cause: assert property (p_nop_cause)
        else $error("forced slot without control write");
    c_stall: cover property ($fell(core_stall));
    c_nop: cover property ($rose(force_nop));
    c_key: cover property (key_q);
endmodule
bind fspc_flash_self_program_control fspc_flash_self_program_control_asserts
    #(.OP_CYCLES(OP_CYCLES)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .instr_retire(instr_retire), .force_nop(force_nop),
    .core_stall(core_stall), .clocks_running(clocks_running));

//--- bench/fspc_core_model.sv
/*
 * Core model: retires one instruction slot every cycle, or every
 * fourth cycle when slow is set. Assumes stall halts the pipeline.
 */
`timescale 1ns/1ps
module fspc_core_model (
    input  wire clk_sys,
    input  wire reset_n,
    input  wire core_stall,
    input  wire slow,
    output reg  instr_retire
);
    reg [1:0] gap_q;
    // A halted core retires nothing, so no slot is lost during erase.
    // Slots under force_nop run as no-ops, never two-cycle ones.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gap_q        <= 2'h0;
            instr_retire <= 1'b0;
        end else begin
            gap_q        <= gap_q + 2'h1;
            instr_retire <= !core_stall && (!slow || gap_q == 2'h3);
        end
    end
endmodule

//--- bench/fspc_flash_self_program_control_test.sv
/*
 * Self-checking bench: an AHB-Lite master task set and the core model.
 * Assumes the zero-wait slave and a shortened operation time.
 */
`timescale 1ns/1ps
`include "fspc_defines.vh"
module fspc_flash_self_program_control_test;
    localparam OPC = 20;
    reg         clk_sys = 1'b0, reset_n = 1'b0, slow = 1'b0, hwrite = 1'b0;
    reg  [11:0] haddr = 12'h0;
    reg  [1:0]  htrans = 2'h0;
    reg  [31:0] hwdata = 32'h0, r;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, instr_retire, force_nop, core_stall, cr;
    integer     miscompares = 0, comparisons = 0, n, nst;
    initial forever #5 clk_sys = ~clk_sys;
    fspc_flash_self_program_control #(.OP_CYCLES(OPC)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .instr_retire(instr_retire), .force_nop(force_nop),
        .core_stall(core_stall), .clocks_running(cr));
    fspc_core_model u_core (.clk_sys(clk_sys), .reset_n(reset_n),
        .core_stall(core_stall), .slow(slow), .instr_retire(instr_retire));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input w, input [11:0] a, input [31:0] d);
        @(posedge clk_sys);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        r = hrdata;
    endtask
    task unlock;
        bus(1, `FSPC_UNLOCK_KEY, 32'h55);
        bus(1, `FSPC_UNLOCK_KEY, 32'haa);
    endtask
    // Wait for slots and stall to end, counting stall cycles.
    task wait_idle;
        n = 0;
        nst = 0;
        while ((force_nop !== 1'b0 || core_stall !== 1'b0) && n < 1000) begin
            @(posedge clk_sys);
            n = n + 1;
            if (core_stall === 1'b1) nst = nst + 1;
        end
        chk(n < 1000, 1);
    endtask
    task rd_word(input [7:0] a, input [13:0] exp);
        bus(1, `FSPC_ADDR_LOW, {24'h0, a});
        bus(1, `FSPC_ADDR_HIGH, 32'h0);
        bus(1, `FSPC_CONTROL, 32'h01);
        #1 chk(force_nop, 1);
        wait_idle;
        bus(0, `FSPC_DATA_LOW, 32'h0);
        chk(r, {24'h0, exp[7:0]});
        bus(0, `FSPC_DATA_HIGH, 32'h0);
        chk(r, {26'h0, exp[13:8]});
    endtask
    task op(input [31:0] ctl, input integer stall);
        unlock;
        bus(1, `FSPC_CONTROL, ctl);
        #1 chk(force_nop, 1);
        wait_idle;
        chk(nst, stall);
    endtask
    task bad(input [7:0] k1, input [7:0] k2, input mid, input [31:0] ctl);
        bus(1, `FSPC_UNLOCK_KEY, {24'h0, k1});
        if (mid) bus(0, `FSPC_ADDR_LOW, 32'h0);
        bus(1, `FSPC_UNLOCK_KEY, {24'h0, k2});
        bus(1, `FSPC_CONTROL, ctl);
        @(posedge clk_sys);
        chk({force_nop, core_stall}, 2'b00);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        bus(0, `FSPC_CONTROL, 32'h0);
        chk(r & ~32'h8, 32'h0);
        chk(cr, 1);
        chk(hresp, 0);
        bus(1, `FSPC_UNLOCK_KEY, 32'h55);
        bus(0, `FSPC_UNLOCK_KEY, 32'h0);
        chk(r, 32'h0);
        bus(0, 12'h0fc, 32'h0);
        chk(r, 32'h0);
    endtask
    task t_erase;
        bus(1, `FSPC_ADDR_LOW, 32'h47);
        bus(1, `FSPC_ADDR_HIGH, 32'h0);
        bus(1, `FSPC_CONTROL, 32'h14);
        slow = 1'b1;
        op(32'h16, OPC);
        slow = 1'b0;
        bus(0, `FSPC_CONTROL, 32'h0);
        chk(r & 32'h3, 32'h0);
        rd_word(8'h40, `FSPC_BLANK_WORD);
        rd_word(8'h5f, `FSPC_BLANK_WORD);
    endtask
    task t_program;
        bus(1, `FSPC_ADDR_LOW, 32'h40);
        bus(1, `FSPC_DATA_LOW, 32'h23);
        bus(1, `FSPC_DATA_HIGH, 32'h01);
        bus(1, `FSPC_CONTROL, 32'h24);
        op(32'h26, 0);
        bus(1, `FSPC_ADDR_LOW, 32'h41);
        bus(1, `FSPC_DATA_LOW, 32'h45);
        bus(1, `FSPC_DATA_HIGH, 32'h2a);
        op(32'h06, OPC);
        rd_word(8'h40, 14'h0123);
        rd_word(8'h41, 14'h2a45);
        repeat (3) @(posedge clk_sys);
        bus(0, `FSPC_DATA_LOW, 32'h0);
        chk(r, 32'h45);
    endtask
    task t_refuse;
        bus(1, `FSPC_ADDR_LOW, 32'h42);
        bus(1, `FSPC_DATA_LOW, 32'h0);
        bus(1, `FSPC_DATA_HIGH, 32'h0);
        bus(1, `FSPC_CONTROL, 32'h04);
        bad(8'h55, 8'h11, 0, 32'h06);
        bad(8'haa, 8'h55, 0, 32'h06);
        bad(8'h55, 8'haa, 1, 32'h06);
        bad(8'h55, 8'haa, 0, 32'h02);
        rd_word(8'h42, `FSPC_BLANK_WORD);
    endtask
    // Reset in the middle of an erase must leave the abort flag set.
    task t_abort;
        bus(1, `FSPC_CONTROL, 32'h14);
        unlock;
        bus(1, `FSPC_CONTROL, 32'h16);
        while (core_stall !== 1'b1) @(posedge clk_sys);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        bus(0, `FSPC_CONTROL, 32'h0);
        chk(r, 32'h8);
        bus(1, `FSPC_CONTROL, 32'h0);
        bus(0, `FSPC_CONTROL, 32'h0);
        chk(r, 32'h0);
    endtask
    initial begin
        #300000;
        miscompares = miscompares + 1;
        final_report;
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset;
        t_erase;
        t_program;
        t_refuse;
        t_abort;
        final_report;
    end
endmodule
